// *** design/iepd_decoder.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Enable-interrupt opcode 0x005 sets the global enable flag.
// - Interrupts become acceptable one cycle after the enable flag is set, two cycles after that instruction.
// - Arming instruction makes a power-down instruction valid only if it is the next valid instruction.
// - Opcode 0x260 loads the accumulator from the first port.
// - Second port-read opcode loads the accumulator from second port.
module iepd_decoder
    import iepd_pkg::*;
#(
    parameter logic [9:0] OPC_PD_ARM = 10'h29d,
    parameter logic [9:0] OPC_PD_A   = 10'h008,
    parameter logic [9:0] OPC_PD_B   = 10'h002
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire logic              instr_valid,
    input  wire logic [OPC_W-1:0]  instr_code,
    input  wire logic [PORT_W-1:0] first_input_port,
    input  wire logic [PORT_W-1:0] second_input_port,
    output logic      [PORT_W-1:0] acc_q,
    output logic                   acc_load_q,
    output logic                   global_irq_enable_flag_q,
    output logic                   irq_accept_q,
    output logic                   powerdown_armed_q,
    output logic                   powerdown_a_q,
    output logic                   powerdown_b_q
);
    // Pin synchronisers: three stages, value taken when stages 2 and 3 agree
    logic [PORT_W-1:0] p0_s1_q, p0_s2_q, p0_s3_q, p0_val_q, p0_val_d;
    logic [PORT_W-1:0] p1_s1_q, p1_s2_q, p1_s3_q, p1_val_q, p1_val_d;

    always_comb begin
        p0_val_d = (p0_s2_q == p0_s3_q) ? p0_s3_q : p0_val_q;
        p1_val_d = (p1_s2_q == p1_s3_q) ? p1_s3_q : p1_val_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            p0_s1_q  <= PORT_RST;
            p0_s2_q  <= PORT_RST;
            p0_s3_q  <= PORT_RST;
            p0_val_q <= PORT_RST;
            p1_s1_q  <= PORT_RST;
            p1_s2_q  <= PORT_RST;
            p1_s3_q  <= PORT_RST;
            p1_val_q <= PORT_RST;
        end else if (clk_en) begin
            p0_s1_q  <= first_input_port;
            p0_s2_q  <= p0_s1_q;
            p0_s3_q  <= p0_s2_q;
            p0_val_q <= p0_val_d;
            p1_s1_q  <= second_input_port;
            p1_s2_q  <= p1_s1_q;
            p1_s3_q  <= p1_s2_q;
            p1_val_q <= p1_val_d;
        end
    end

    // Instruction decode and execute
    logic              is_ie, is_rd0, is_rd1, is_arm, is_pda, is_pdb;
    logic [PORT_W-1:0] acc_d;
    logic              acc_load_d, ie_d, accept_d, armed_d, pda_d, pdb_d;

    // Opcode match, qualified by the valid strobe
    function automatic logic opc_hit(
        input logic             valid,
        input logic [OPC_W-1:0] code,
        input logic [OPC_W-1:0] opc
    );
        return valid && (code == opc);
    endfunction : opc_hit

    always_comb begin
        is_ie  = opc_hit(instr_valid, instr_code, OPC_IRQ_ENABLE);
        is_rd0 = opc_hit(instr_valid, instr_code, OPC_READ_FIRST);
        is_rd1 = opc_hit(instr_valid, instr_code, OPC_READ_SECOND);
        is_arm = opc_hit(instr_valid, instr_code, OPC_PD_ARM);
        is_pda = opc_hit(instr_valid, instr_code, OPC_PD_A);
        is_pdb = opc_hit(instr_valid, instr_code, OPC_PD_B);
        acc_d      = acc_q;
        acc_load_d = 1'b0;
        if (is_rd0) begin
            acc_d      = p0_val_q;
            acc_load_d = 1'b1;
        end else if (is_rd1) begin
            acc_d      = p1_val_q;
            acc_load_d = 1'b1;
        end
        ie_d     = global_irq_enable_flag_q | is_ie;
        accept_d = global_irq_enable_flag_q;
        armed_d  = instr_valid ? is_arm : powerdown_armed_q;
        pda_d    = is_pda && powerdown_armed_q;
        pdb_d    = is_pdb && powerdown_armed_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            acc_q                    <= PORT_RST;
            acc_load_q               <= 1'b0;
            global_irq_enable_flag_q <= 1'b0;
            irq_accept_q             <= 1'b0;
            powerdown_armed_q        <= 1'b0;
            powerdown_a_q            <= 1'b0;
            powerdown_b_q            <= 1'b0;
        end else if (clk_en) begin
            acc_q                    <= acc_d;
            acc_load_q               <= acc_load_d;
            global_irq_enable_flag_q <= ie_d;
            irq_accept_q             <= accept_d;
            powerdown_armed_q        <= armed_d;
            powerdown_a_q            <= pda_d;
            powerdown_b_q            <= pdb_d;
        end
    end

    // Checks
    property p_ie_sets;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && is_ie) |=> global_irq_enable_flag_q;
    endproperty
    a_ie_sets: assert property (p_ie_sets)
        else $error("Enable flag not set after enable instruction");

    property p_accept_delay;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && is_ie && !global_irq_enable_flag_q)
            |=> global_irq_enable_flag_q && !irq_accept_q;
    endproperty
    a_accept_delay: assert property (p_accept_delay)
        else $error("Interrupt acceptance not delayed by one cycle");

    property p_pd_valid;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && powerdown_armed_q && is_pda) |=> powerdown_a_q;
    endproperty
    a_pd_valid: assert property (p_pd_valid)
        else $error("Armed power-down instruction not issued");

    property p_rd0;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && is_rd0) |=> (acc_q == $past(p0_val_q)) && acc_load_q;
    endproperty
    a_rd0: assert property (p_rd0)
        else $error("Accumulator not loaded from first port");

    property p_rd1;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && is_rd1) |=> (acc_q == $past(p1_val_q)) && acc_load_q;
    endproperty
    a_rd1: assert property (p_rd1)
        else $error("Accumulator not loaded from second port");

    property p_pd_nop;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && !powerdown_armed_q && (is_pda || is_pdb))
            |=> !powerdown_a_q && !powerdown_b_q;
    endproperty
    a_pd_nop: assert property (p_pd_nop)
        else $error("Unarmed power-down instruction took effect");

    property p_arm_clear;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && instr_valid && !is_arm) |=> !powerdown_armed_q;
    endproperty
    a_arm_clear: assert property (p_arm_clear)
        else $error("Arming not cleared by other instruction");

    property p_arm_set;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && is_arm) |=> powerdown_armed_q;
    endproperty
    a_arm_set: assert property (p_arm_set)
        else $error("Arming instruction did not arm");

    property p_accept_follow;
        @(posedge clock) disable iff (!rst_b)
        clk_en |=> (irq_accept_q == $past(global_irq_enable_flag_q));
    endproperty
    a_accept_follow: assert property (p_accept_follow)
        else $error("Acceptance does not follow the enable flag");

    property p_ie_hold;
        @(posedge clock) disable iff (!rst_b)
        global_irq_enable_flag_q |=> global_irq_enable_flag_q;
    endproperty
    a_ie_hold: assert property (p_ie_hold)
        else $error("Enable flag dropped without reset");

    property p_pdb_valid;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && powerdown_armed_q && is_pdb) |=> powerdown_b_q;
    endproperty
    a_pdb_valid: assert property (p_pdb_valid)
        else $error("Armed second power-down instruction not issued");

    property p_pd_pulse;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && !is_pda && !is_pdb)
            |=> !powerdown_a_q && !powerdown_b_q;
    endproperty
    a_pd_pulse: assert property (p_pd_pulse)
        else $error("Power-down pulse without power-down instruction");

    property p_acc_hold;
        @(posedge clock) disable iff (!rst_b)
        !(clk_en && (is_rd0 || is_rd1)) |=> $stable(acc_q);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("Accumulator changed without a port read");

    property p_acc_pulse;
        @(posedge clock) disable iff (!rst_b)
        (clk_en && !is_rd0 && !is_rd1) |=> !acc_load_q;
    endproperty
    a_acc_pulse: assert property (p_acc_pulse)
        else $error("Load pulse without a port read");

    property p_freeze_arm;
        @(posedge clock) disable iff (!rst_b)
        !clk_en |=> $stable(powerdown_armed_q);
    endproperty
    a_freeze_arm: assert property (p_freeze_arm)
        else $error("Arming state changed while frozen");

    c_ie: cover property (@(posedge clock) disable iff (!rst_b)
        is_ie && clk_en ##1 clk_en ##1 irq_accept_q);
    c_pd: cover property (@(posedge clock) disable iff (!rst_b)
        is_arm && clk_en ##1 is_pdb && clk_en ##1 powerdown_b_q);
    c_rd: cover property (@(posedge clock) disable iff (!rst_b)
        is_rd1 && clk_en ##1 acc_load_q);
    c_freeze: cover property (@(posedge clock) disable iff (!rst_b)
        !clk_en && powerdown_armed_q ##2 clk_en && is_pda ##1 powerdown_a_q);
endmodule : iepd_decoder

// *** design/iepd_pkg.sv ***
package iepd_pkg;
    localparam int          OPC_W           = 10;
    localparam int          PORT_W          = 4;
    localparam int          ACC_RST         = 0;
    localparam logic [9:0]  OPC_IRQ_ENABLE  = 10'h005;
    localparam logic [9:0]  OPC_READ_FIRST  = 10'h260;
    localparam logic [9:0]  OPC_READ_SECOND = 10'h261;
    localparam int          IRQ_DELAY_CYC   = 1;
    localparam logic [3:0]  PORT_RST        = 4'h0;
endpackage : iepd_pkg

// *** verif/iepd_pin_model.sv ***
`timescale 1ns/1ps
// Port pins as seen from outside; they follow the bench-set levels
module iepd_pin_model
    import iepd_pkg::*;
(
    input  wire logic              clock,
    input  wire logic [PORT_W-1:0] lvl_a,
    input  wire logic [PORT_W-1:0] lvl_b,
    output logic      [PORT_W-1:0] pin_a,
    output logic      [PORT_W-1:0] pin_b
);
    always_ff @(posedge clock) begin
        pin_a <= lvl_a;
        pin_b <= lvl_b;
    end
endmodule : iepd_pin_model

// *** verif/int_enable_powerdown_arm_port_read_test.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t mismatch", $time); end end
module int_enable_powerdown_arm_port_read_test;
    import iepd_pkg::*;
    logic clock, rst_b, clk_en, instr_valid;
    logic [OPC_W-1:0] instr_code;
    logic [PORT_W-1:0] lvl_a, lvl_b, pin_a, pin_b, acc_q;
    logic acc_load_q, flag_q, accept_q, armed_q, pd_a_q, pd_b_q;
    int bad_count, checks_done;
    iepd_pin_model iepd_pin_model_inst (.clock(clock), .lvl_a(lvl_a),
        .lvl_b(lvl_b), .pin_a(pin_a), .pin_b(pin_b));
    iepd_decoder iepd_decoder_inst (.clock(clock), .rst_b(rst_b),
        .clk_en(clk_en), .instr_valid(instr_valid), .instr_code(instr_code),
        .first_input_port(pin_a), .second_input_port(pin_b),
        .acc_q(acc_q), .acc_load_q(acc_load_q),
        .global_irq_enable_flag_q(flag_q), .irq_accept_q(accept_q),
        .powerdown_armed_q(armed_q), .powerdown_a_q(pd_a_q),
        .powerdown_b_q(pd_b_q));
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    task issue(input logic [OPC_W-1:0] c);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_code  <= c;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask : issue
    task idle();
        @(posedge clock) instr_valid <= 0;
        #1;
    endtask : idle
    task t_irq();
        `CHK(flag_q, 1'b0)
        issue(OPC_IRQ_ENABLE);
        `CHK(flag_q, 1'b1)
        `CHK(accept_q, 1'b0)
        idle();
        `CHK(accept_q, 1'b1)
    endtask : t_irq
    task t_pd();
        issue(10'h008);
        `CHK(pd_a_q, 1'b0)
        issue(10'h29d);
        `CHK(armed_q, 1'b1)
        issue(10'h008);
        `CHK(pd_a_q, 1'b1)
        `CHK(armed_q, 1'b0)
        issue(10'h29d);
        issue(10'h3ff);
        `CHK(armed_q, 1'b0)
        issue(10'h002);
        `CHK(pd_b_q, 1'b0)
        issue(10'h29d);
        idle();
        idle();
        issue(10'h002);
        `CHK(pd_b_q, 1'b1)
    endtask : t_pd
    task t_port(input logic [PORT_W-1:0] a, input logic [PORT_W-1:0] b);
        @(posedge clock) begin lvl_a <= a; lvl_b <= b; end
        repeat (6) @(posedge clock);
        issue(OPC_READ_FIRST);
        `CHK(acc_q, a)
        `CHK(acc_load_q, 1'b1)
        issue(OPC_READ_SECOND);
        `CHK(acc_q, b)
        idle();
        `CHK(acc_load_q, 1'b0)
    endtask : t_port
    task t_reset();
        issue(10'h29d);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        `CHK(acc_q, 4'h0)
        `CHK(acc_load_q, 1'b0)
        `CHK(flag_q, 1'b0)
        `CHK(accept_q, 1'b0)
        `CHK(armed_q, 1'b0)
        `CHK(pd_a_q, 1'b0)
        `CHK(pd_b_q, 1'b0)
    endtask : t_reset
    task t_freeze();
        issue(10'h29d);
        @(posedge clock);
        clk_en <= 1'b0;
        issue(10'h3ff);
        `CHK(armed_q, 1'b1)
        @(posedge clock);
        clk_en <= 1'b1;
        issue(10'h008);
        `CHK(pd_a_q, 1'b1)
        idle();
        `CHK(pd_a_q, 1'b0)
    endtask : t_freeze
    task stop_test();
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (800) @(posedge clock);
        bad_count++;
        stop_test();
    end
    initial begin
        rst_b = 0; clk_en = 1; instr_valid = 0; instr_code = 0;
        lvl_a = 0; lvl_b = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1;
        t_irq();
        t_port(4'ha, 4'h5);
        t_reset();
        t_irq();
        t_pd();
        t_freeze();
        t_port(4'hf, 4'h0);
        stop_test();
    end
endmodule : int_enable_powerdown_arm_port_read_test
